//--- logic/mcm_pkg.sv
package mcm_pkg;
  // register offsets
  localparam logic [8:0] ADDR_POWER_MODE = 9'h008;
  localparam logic [8:0] ADDR_LOOP_ENABLE = 9'h009;
  localparam logic [8:0] ADDR_MULT_CTRL = 9'h00a;
  localparam logic [8:0] ADDR_RATIO = 9'h101;
  // field positions
  localparam int LOOP_ENABLE_BIT = 2;
  localparam int AUTOBAND_BIT = 6;
  localparam int LOCKED_BIT = 7;
  localparam int FACTOR_MSB = 5;
  localparam int RATIO_MSB = 5;
  // reset values
  localparam logic [7:0] POWER_MODE_RST = 8'h00;
  localparam logic [7:0] LOOP_ENABLE_RST = 8'h00;
  localparam logic [7:0] MULT_CTRL_RST = 8'h00;
  localparam logic [7:0] RATIO_RST = 8'h00;
  // power mode encodings
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_POWER_DOWN = 2'h1;
  localparam logic [1:0] PM_STANDBY = 2'h2;
  localparam logic [1:0] PM_SLEEP = 2'h3;
  // strap code that selects direct clocking
  localparam logic [4:0] STRAP_DIRECT = 5'h1f;
  // modulator clock is the oscillator divided by this
  localparam logic [1:0] MOD_DIV = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BAND_SETTLE_NS = 1000;
  localparam int LOCK_WAIT_NS = 10000;
  localparam int BAND_SETTLE_CYC = (BAND_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_WAIT_CYC = (LOCK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {S_OFF, S_BAND, S_PICK, S_LOCK, S_LOCKED} mcm_state_t;
endpackage

//--- logic/mcm_factor_dec.sv
`timescale 1ns/10ps
module mcm_factor_dec (
  // codes
  input wire logic [5:0] reg_code,
  input wire logic [4:0] strap_code,
  // decoded factors
  output logic [5:0] reg_n,
  output logic [5:0] strap_n
);

  function automatic logic [5:0] dec_reg(input logic [5:0] c);
    logic [5:0] n;
    n = 6'h08;
    if (c >= 6'd42) n = 6'd42;
    else if (c >= 6'd34) n = 6'd34;
    else if (c >= 6'd32) n = 6'd32;
    else if (c >= 6'd30) n = 6'd30;
    else if (c >= 6'd28) n = 6'd28;
    else if (c >= 6'd25) n = 6'd25;
    else if (c >= 6'd24) n = 6'd24;
    else if (c >= 6'd21) n = 6'd21;
    else if (c >= 6'd20) n = 6'd20;
    else if (c >= 6'd18) n = 6'd18;
    else if (c >= 6'd12 && c <= 6'd17) n = (c == 6'd13) ? 6'd12 : c;
    else if (c >= 6'd10) n = 6'd10;
    else if (c == 6'd9) n = 6'd9;
    return n;
  endfunction

  function automatic logic [5:0] dec_strap(input logic [4:0] c);
    logic [5:0] n;
    case (c)
      5'h00: n = 6'd8;
      5'h01: n = 6'd9;
      5'h02: n = 6'd10;
      5'h03: n = 6'd12;
      5'h04: n = 6'd14;
      5'h05: n = 6'd15;
      5'h06: n = 6'd16;
      5'h07: n = 6'd17;
      5'h08: n = 6'd18;
      5'h09: n = 6'd20;
      5'h0a: n = 6'd21;
      5'h0b: n = 6'd24;
      5'h0c: n = 6'd25;
      5'h0d: n = 6'd28;
      5'h0e: n = 6'd30;
      5'h0f: n = 6'd32;
      5'h10: n = 6'd34;
      default: n = 6'd42;
    endcase
    return n;
  endfunction

  // code 1..8 share 8, code 0 treated the same
  assign reg_n = dec_reg(reg_code); // (R10)
  assign strap_n = dec_strap(strap_code); // (R13)

endmodule

//--- logic/mcm_ctrl.sv
`timescale 1ns/10ps
// Contract
// (R1) after reset the modulator clock comes straight from the clock input pair; code selects the loop on the first clock unless the straps read 31
// (R2) with the loop on, oscillator runs at reference times factor N
// (R3) modulator clock is the oscillator halved, giving equal high and low times
// (R4) host supplies a 30 to 160 MHz reference when the loop is selected
// (R5) host writes the six-bit factor before setting loop enable
// (R6) once enabled and locked, lock shows in bit 7 of the multiplier control
// (R7) host toggles loop enable after changing the factor
// (R8) host bring-up: reference, factor, enable 4, autoband, ratio reset, ratio
// (R9) host resets rate converter by writing ratio zero, then the real ratio
// (R10) register factor code decodes to N by the stepped table
// (R11) serial interface stays disabled until the first serial access
// (R12) while serial interface is disabled, strap pins give the factor
// (R13) strap codes 0..16 map to listed N, 17..30 give 42
// (R14) strap code 31 disables the loop and selects direct clocking
// (R15) bit 6 of multiplier control starts automatic band selection
// (R16) band selection picks the best of the overlapping valid bands
// (R17) host toggles autoband after leaving sleep or standby
// (R18) power mode field selects normal, power-down, standby, sleep; latter two stop clocks
// (R19) host keeps modulator clock at 640 MHz within five percent
// (R20) lock reads zero while loop enable is clear and clears on restart; code still returns a strap-mode lock when the first serial access reads it
module mcm_ctrl #(
  parameter int NUM_BANDS = 16,
  parameter int BAND_SETTLE = mcm_pkg::BAND_SETTLE_CYC,
  parameter int LOCK_WAIT = mcm_pkg::LOCK_WAIT_CYC,
  parameter int BW = $clog2(NUM_BANDS)
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // serial port register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // strap pins
  input wire logic [4:0] multiplier_strap_pins,
  // analog loop feedback
  input wire logic band_in_range,
  input wire logic loop_lock_detect,
  // analog loop control
  output logic direct_clock_sel,
  output logic loop_power_on,
  output logic [5:0] loop_multiplier_factor,
  output logic [1:0] modulator_clock_div,
  output logic [BW-1:0] band_sel,
  output logic clocks_stopped,
  output logic analog_off,
  output logic rate_converter_reset,
  output logic [5:0] rate_converter_ratio
);

  // cnt_r is 14 bits wide, so longer waits cannot be counted
  if (NUM_BANDS < 2 || BW != $clog2(NUM_BANDS) || BAND_SETTLE < 1 || LOCK_WAIT < 1
      || BAND_SETTLE > 16384 || LOCK_WAIT > 16384)
    $error("mcm_ctrl: unsupported parameter values");

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic spi_active_r, locked_r, access, stop_clk;
  logic [1:0] power_mode_r;
  logic [7:0] loop_enable_r;
  logic [6:0] mult_ctrl_r;
  logic [5:0] ratio_r;

  assign access = reg_wr | reg_rd;
  assign stop_clk = power_mode_r == mcm_pkg::PM_STANDBY || power_mode_r == mcm_pkg::PM_SLEEP;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      spi_active_r <= 1'b0;
    else if (access)
      spi_active_r <= 1'b1; // (R11)
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      power_mode_r <= mcm_pkg::POWER_MODE_RST[1:0];
      loop_enable_r <= mcm_pkg::LOOP_ENABLE_RST;
      mult_ctrl_r <= mcm_pkg::MULT_CTRL_RST[6:0];
      ratio_r <= mcm_pkg::RATIO_RST[5:0];
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        mcm_pkg::ADDR_POWER_MODE: power_mode_r <= reg_wdata[1:0]; // (R18)
        mcm_pkg::ADDR_LOOP_ENABLE: loop_enable_r <= reg_wdata;
        mcm_pkg::ADDR_MULT_CTRL: mult_ctrl_r <= reg_wdata[6:0]; // lock bit is read-only
        mcm_pkg::ADDR_RATIO: ratio_r <= reg_wdata[mcm_pkg::RATIO_MSB:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        case (reg_addr)
          mcm_pkg::ADDR_POWER_MODE: reg_rdata <= {6'h00, power_mode_r};
          mcm_pkg::ADDR_LOOP_ENABLE: reg_rdata <= loop_enable_r;
          mcm_pkg::ADDR_MULT_CTRL: reg_rdata <= {locked_r, mult_ctrl_r}; // (R6)
          mcm_pkg::ADDR_RATIO: reg_rdata <= {2'h0, ratio_r};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // factor source and clock selection
  logic [5:0] reg_n, strap_n, n_sel;
  logic strap_direct, loop_want, autoband_on;

  mcm_factor_dec u_dec (
    .reg_code(mult_ctrl_r[mcm_pkg::FACTOR_MSB:0]),
    .strap_code(multiplier_strap_pins),
    .reg_n(reg_n),
    .strap_n(strap_n)
  );

  assign strap_direct = multiplier_strap_pins == mcm_pkg::STRAP_DIRECT; // (R14)
  // strap mode has no register to ask for autoband, so it always runs
  assign loop_want = spi_active_r ? loop_enable_r[mcm_pkg::LOOP_ENABLE_BIT] : !strap_direct;
  assign n_sel = spi_active_r ? reg_n : strap_n; // (R12)
  assign autoband_on = spi_active_r ? mult_ctrl_r[mcm_pkg::AUTOBAND_BIT] : 1'b1;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      direct_clock_sel <= 1'b1; // (R1)
      loop_power_on <= 1'b0;
      loop_multiplier_factor <= 6'h08;
      modulator_clock_div <= 2'h1;
      clocks_stopped <= 1'b0;
      analog_off <= 1'b0;
    end
    else
    begin
      direct_clock_sel <= !loop_want; // (R14)
      loop_power_on <= loop_want && !stop_clk; // (R18)
      loop_multiplier_factor <= n_sel; // (R2)
      // oscillator halved only when it feeds the modulator
      modulator_clock_div <= loop_want ? mcm_pkg::MOD_DIV : 2'h1; // (R3)
      clocks_stopped <= stop_clk; // (R18)
      analog_off <= power_mode_r != mcm_pkg::PM_NORMAL;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rate_converter_ratio <= 6'h00;
      rate_converter_reset <= 1'b1;
    end
    else
    begin
      rate_converter_ratio <= ratio_r;
      rate_converter_reset <= ratio_r == 6'h00; // (R9)
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // band search and lock sequencing
  mcm_pkg::mcm_state_t state_r;
  logic run, run_d_r, ab_d_r, restart, found_r;
  logic [5:0] n_d_r;
  logic [13:0] cnt_r;
  logic [BW-1:0] scan_r, first_r, last_r;
  logic [BW:0] mid;

  assign run = loop_want && !stop_clk;
  // a factor change or autoband rise retunes the loop from scratch
  assign restart = (run && !run_d_r) || (autoband_on && !ab_d_r) || (n_sel != n_d_r);
  assign mid = ({1'b0, first_r} + {1'b0, last_r}) >> 1;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_d_r <= 1'b0;
      ab_d_r <= 1'b0;
      n_d_r <= 6'h08;
    end
    else
    begin
      run_d_r <= run;
      ab_d_r <= autoband_on;
      n_d_r <= n_sel;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r <= mcm_pkg::S_OFF;
      cnt_r <= 14'h0000;
      scan_r <= '0;
      first_r <= '0;
      last_r <= '0;
      found_r <= 1'b0;
      band_sel <= BW'(NUM_BANDS / 2);
    end
    else if (!run)
      state_r <= mcm_pkg::S_OFF; // (R20)
    else if (restart)
    begin
      cnt_r <= 14'h0000;
      scan_r <= '0;
      found_r <= 1'b0;
      if (autoband_on)
      begin
        state_r <= mcm_pkg::S_BAND; // (R15)
        band_sel <= '0;
      end
      else
        state_r <= mcm_pkg::S_LOCK;
    end
    else
    begin
      case (state_r)
        mcm_pkg::S_BAND:
        begin
          if (cnt_r == 14'(BAND_SETTLE - 1))
          begin
            cnt_r <= 14'h0000;
            if (band_in_range)
            begin
              if (!found_r)
                first_r <= scan_r;
              last_r <= scan_r;
              found_r <= 1'b1;
            end
            if (scan_r == BW'(NUM_BANDS - 1))
              state_r <= mcm_pkg::S_PICK;
            else
            begin
              scan_r <= scan_r + 1'b1;
              band_sel <= scan_r + 1'b1;
            end
          end
          else
            cnt_r <= cnt_r + 1'b1;
        end
        mcm_pkg::S_PICK:
        begin
          // middle of the in-range run sits furthest from both band edges
          band_sel <= found_r ? mid[BW-1:0] : BW'(NUM_BANDS / 2); // (R16)
          state_r <= mcm_pkg::S_LOCK;
        end
        mcm_pkg::S_LOCK:
        begin
          if (!loop_lock_detect)
            cnt_r <= 14'h0000;
          else if (cnt_r == 14'(LOCK_WAIT - 1))
            state_r <= mcm_pkg::S_LOCKED;
          else
            cnt_r <= cnt_r + 1'b1;
        end
        mcm_pkg::S_LOCKED:
        begin
          if (!loop_lock_detect)
          begin
            cnt_r <= 14'h0000;
            state_r <= mcm_pkg::S_LOCK;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      locked_r <= 1'b0;
    else
      locked_r <= run && !restart && state_r == mcm_pkg::S_LOCKED; // (R6) (R20)
  end

endmodule

//--- verification/mcm_ctrl_asserts.sv
`timescale 1ns/10ps
module mcm_ctrl_asserts (
  // clock, reset, register port
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // loop and converter controls
  input wire logic direct_clock_sel,
  input wire logic loop_power_on,
  input wire logic [1:0] modulator_clock_div,
  input wire logic clocks_stopped,
  input wire logic analog_off,
  input wire logic rate_converter_reset,
  input wire logic [5:0] rate_converter_ratio
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic en_r;
  logic ctl_r;
  logic pm_wr;
  logic ra_wr;
  assign pm_wr = reg_wr && reg_addr == mcm_pkg::ADDR_POWER_MODE;
  assign ra_wr = reg_wr && reg_addr == mcm_pkg::ADDR_RATIO;
  ////////////////////////////////////////////////////////////////////////////
  // enable shadow from host writes, so a stuck lock bit cannot hide
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      en_r <= 1'b0;
    else if (reg_wr && reg_addr == mcm_pkg::ADDR_LOOP_ENABLE)
      en_r <= reg_wdata[mcm_pkg::LOOP_ENABLE_BIT];
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      ctl_r <= 1'b0;
    else if (reg_rd)
      ctl_r <= reg_addr == mcm_pkg::ADDR_MULT_CTRL;
  ////////////////////////////////////////////////////////////////////////////
  chk_div_half: assert property (modulator_clock_div == (direct_clock_sel ? 2'h1 : mcm_pkg::MOD_DIV))
    else $error("divider not two");
  chk_rd_answer: assert property (reg_rd |-> ##[1:2] reg_rvalid)
    else $error("read not answered");
  chk_lock_idle: assert property (reg_rvalid && ctl_r && !en_r |-> !reg_rdata[7])
    else $error("lock shown while disabled");
  chk_loop_drop: assert property (reg_wr && reg_addr == mcm_pkg::ADDR_LOOP_ENABLE
    && !reg_wdata[2] |-> ##[1:2] !loop_power_on) else $error("loop kept on");
  chk_direct_idle: assert property (direct_clock_sel |-> !loop_power_on)
    else $error("loop on in direct mode");
  chk_stop_modes: assert property (pm_wr && reg_wdata[1]
    |-> ##[1:2] clocks_stopped && analog_off) else $error("clocks not stopped");
  chk_pdwn_mode: assert property (pm_wr && reg_wdata[1:0] == mcm_pkg::PM_POWER_DOWN
    |-> ##[1:2] analog_off && !clocks_stopped) else $error("power-down wrong");
  chk_normal_mode: assert property (pm_wr && reg_wdata[1:0] == mcm_pkg::PM_NORMAL
    |-> ##[1:2] !analog_off && !clocks_stopped) else $error("normal mode wrong");
  chk_ratio_load: assert property (ra_wr
    |-> ##2 rate_converter_ratio == $past(reg_wdata[5:0], 2)) else $error("ratio not loaded");
  chk_src_reset: assert property (ra_wr && reg_wdata[5:0] == 6'h00
    |-> ##[1:2] rate_converter_reset) else $error("converter not reset");
endmodule
bind mcm_ctrl mcm_ctrl_asserts u_chk (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .direct_clock_sel(direct_clock_sel), .loop_power_on(loop_power_on),
  .modulator_clock_div(modulator_clock_div), .clocks_stopped(clocks_stopped),
  .analog_off(analog_off), .rate_converter_reset(rate_converter_reset),
  .rate_converter_ratio(rate_converter_ratio));

//--- verification/mcm_loop_model.sv
`timescale 1ns/10ps
module mcm_loop_model #(
  parameter int BW = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // loop controls and bench knobs
  input wire logic loop_power_on,
  input wire logic [BW-1:0] band_sel,
  input wire logic slow,
  input wire logic [BW-1:0] target,
  // feedback
  output logic band_in_range,
  output logic loop_lock_detect
);
  // rates not modelled; keeping 640 MHz within five percent is the host's job
  logic [7:0] cnt_r;
  // three overlapping bands reach the wanted frequency; target kept below 14
  assign band_in_range = loop_power_on && band_sel >= target && band_sel <= target + 2'h2;
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      cnt_r <= 8'h00;
    else if (!loop_power_on)
      cnt_r <= 8'h00;
    else if (cnt_r != 8'hff)
      cnt_r <= cnt_r + 8'h01;
  assign loop_lock_detect = cnt_r >= (slow ? 8'h28 : 8'h03);
endmodule

//--- verification/tb_modulator_clock_multiplier_ctrl.sv
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t compare failed, got %0h want %0h", $time, (a), (e)); end end
module tb_modulator_clock_multiplier_ctrl;
  logic clk = 1'b0;
  logic arst_n, wr, rd, rvalid, slow, in_rng, lock_det, direct, pwr_on, stopped, aoff, src_rst;
  logic [8:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [4:0] strap;
  logic [5:0] factor, ratio, v;
  logic [1:0] div;
  logic [3:0] band, target;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  localparam logic [5:0] SN [17] = '{6'h08, 6'h09, 6'h0a, 6'h0c, 6'h0e, 6'h0f, 6'h10, 6'h11,
    6'h12, 6'h14, 6'h15, 6'h18, 6'h19, 6'h1c, 6'h1e, 6'h20, 6'h22};
  mcm_ctrl #(.BAND_SETTLE(4), .LOCK_WAIT(20)) dut (.clk(clk), .arst_n(arst_n), .reg_wr(wr),
    .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .multiplier_strap_pins(strap), .band_in_range(in_rng), .loop_lock_detect(lock_det),
    .direct_clock_sel(direct), .loop_power_on(pwr_on), .loop_multiplier_factor(factor),
    .modulator_clock_div(div), .band_sel(band), .clocks_stopped(stopped), .analog_off(aoff),
    .rate_converter_reset(src_rst), .rate_converter_ratio(ratio));
  mcm_loop_model #(.BW(4)) u_loop (.clk(clk), .arst_n(arst_n), .loop_power_on(pwr_on),
    .band_sel(band), .slow(slow), .target(target), .band_in_range(in_rng),
    .loop_lock_detect(lock_det));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] reg_n(input logic [5:0] c);
    logic [5:0] n;
    n = 6'h08;
    for (int i = 0; i < 17; i++)
      if (SN[i] <= c) n = SN[i];
    return c >= 6'h2a ? 6'h2a : n;
  endfunction
  task automatic conclude(input int hung);
    fails += hung;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wrt(input logic [8:0] a, input logic [7:0] x);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= x;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [8:0] a);
    int k;
    k = 0;
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    while (rvalid !== 1'b1 && k < 8)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    `CHK(rvalid, 1'b1)
    d = rdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic wait_lock();
    d = 8'h00;
    for (int k = 0; k < 60 && d[7] !== 1'b1; k++)
      rdr(mcm_pkg::ADDR_MULT_CTRL);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  always @(posedge clk)
    if (++cyc == 20000)
      conclude(1);
  initial
  begin
    {arst_n, wr, rd, slow} = 4'h0;
    addr = 9'h000;
    wdata = 8'h00;
    strap = 5'h1f;
    target = 4'h5;
    void'($urandom(32'h1ed97189));
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    settle();
    `CHK(direct, 1'b1)
    `CHK(pwr_on, 1'b0)
    `CHK(div, 2'h1)
    $display("reset test done");
    // straps rule until the port is touched; a few random codes follow
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      strap <= i < 31 ? i[4:0] : 5'($urandom_range(30));
      settle();
      `CHK(factor, strap <= 5'h10 ? SN[strap] : 6'h2a)
    end
    // all straps high again: loop off, so no lock can leak into the first read
    @(posedge clk);
    strap <= 5'h1f;
    settle();
    `CHK(direct, 1'b1)
    $display("strap test done");
    rdr(mcm_pkg::ADDR_MULT_CTRL);
    `CHK(d, mcm_pkg::MULT_CTRL_RST)
    rdr(mcm_pkg::ADDR_LOOP_ENABLE);
    `CHK(d, mcm_pkg::LOOP_ENABLE_RST)
    for (int c = 1; c < 64; c++)
    begin
      @(posedge clk);
      strap <= 5'($urandom());
      wrt(mcm_pkg::ADDR_MULT_CTRL, {2'h0, c[5:0]});
      settle();
      `CHK(factor, reg_n(c[5:0]))
    end
    $display("factor test done");
    @(posedge clk);
    target <= 4'($urandom_range(13));
    wrt(mcm_pkg::ADDR_MULT_CTRL, 8'h15);
    wrt(mcm_pkg::ADDR_LOOP_ENABLE, 8'h04);
    wrt(mcm_pkg::ADDR_MULT_CTRL, 8'h55);
    wait_lock();
    `CHK(d[7], 1'b1)
    `CHK({pwr_on, direct, factor}, {2'h2, 6'h15})
    `CHK(div, mcm_pkg::MOD_DIV)
    `CHK(in_rng, 1'b1)
    v = 6'($urandom_range(63, 1));
    wrt(mcm_pkg::ADDR_RATIO, 8'h00);
    settle();
    `CHK(src_rst, 1'b1)
    wrt(mcm_pkg::ADDR_RATIO, {2'h0, v});
    rdr(mcm_pkg::ADDR_RATIO);
    `CHK(d[5:0], v)
    `CHK(ratio, v)
    `CHK(src_rst, 1'b0)
    $display("bring-up test done");
    wrt(mcm_pkg::ADDR_MULT_CTRL, 8'h4a);
    wrt(mcm_pkg::ADDR_LOOP_ENABLE, 8'h00);
    rdr(mcm_pkg::ADDR_MULT_CTRL);
    `CHK(d[7], 1'b0)
    @(posedge clk);
    slow <= 1'b1;
    wrt(mcm_pkg::ADDR_LOOP_ENABLE, 8'h04);
    rdr(mcm_pkg::ADDR_MULT_CTRL);
    `CHK(d[7], 1'b0)
    wait_lock();
    `CHK(d[7], 1'b1)
    `CHK(factor, 6'h0a)
    $display("restart test done");
    for (int i = 1; i < 5; i++)
    begin
      wrt(mcm_pkg::ADDR_POWER_MODE, {6'h00, i[1:0]});
      settle();
      `CHK(stopped, i[1])
      `CHK(aoff, i[1:0] != 2'h0)
    end
    wrt(mcm_pkg::ADDR_MULT_CTRL, 8'h0a);
    wrt(mcm_pkg::ADDR_MULT_CTRL, 8'h4a);
    wait_lock();
    `CHK(d[7], 1'b1)
    `CHK(in_rng, 1'b1)
    $display("power mode test done");
    conclude(0);
  end
endmodule
